// >>> spf_defines.svh
// Purpose: shared constants of the packet readout framer
// Assumes: included by its bare name
// Notes:   offsets are byte addresses on the register bus
`ifndef SPF_DEFINES_SVH
`define SPF_DEFINES_SVH

// register map
`define SPF_ADR_CTRL      8'h00
`define SPF_ADR_STAT      8'h04
`define SPF_CTRL_PROT     0
`define SPF_CTRL_EHDR     1
`define SPF_CTRL_PH_LO    2
`define SPF_CTRL_PH_HI    3
`define SPF_CTRL_RST      4'h7
`define SPF_STAT_UNDR     0

// packet format
`define SPF_SYNC_WORD     32'h0000000A
`define SPF_HDR_REV       2'h0
`define SPF_WIDTH_12      2'h2
`define SPF_SMP_BITS      12
`define SPF_META_BITS     5'h10
`define SPF_KIND_EMPTY    3'h0
`define SPF_KIND_VIS      3'h2
`define SPF_KIND_META     3'h3
`define SPF_KIND_OB       3'h4
`define SPF_REPS_PROT     2'h3
`define SPF_REPS_PLAIN    2'h1
`define SPF_CRC_INIT      16'hFFFF
`define SPF_CRC_POLY      16'h1021
`define SPF_LFSR_SEED     16'hACE1

// forwarded clock phase codes
`define SPF_PH_0          2'h0
`define SPF_PH_90         2'h1
`define SPF_PH_180        2'h2
`define SPF_PH_270        2'h3

`endif

// >>> spf_pkg.sv
// Purpose: types of the packet readout framer
// Assumes: nothing
// Notes:   header struct matches the 32-bit header bit layout
package spf_pkg;

    typedef struct packed {
        logic [11:0] payload_pixel_count;
        logic [1:0]  row_mod4;
        logic        frame_end_row_flag;
        logic        frame_start_row_flag;
        logic [7:0]  packet_index;
    } spf_desc_t;

    typedef struct packed {
        logic [11:0] payload_pixel_count;
        logic        padded_flag;
        logic [1:0]  row_mod4;
        logic        frame_end_row_flag;
        logic        frame_start_row_flag;
        logic [1:0]  sample_width_code;
        logic [7:0]  packet_index;
        logic [2:0]  packet_kind;
        logic [1:0]  header_format_rev;
    } spf_hdr_t;

    typedef struct packed {
        logic global_sample_active;
        logic short_group_integrating;
        logic long_group_integrating;
    } spf_meta_t;

    typedef enum logic [1:0] {ST_SYNC, ST_HDR, ST_PAY, ST_CRC} spf_state_t;

endpackage

// >>> spf_framer.sv
// Purpose: packet framer for the pixel, black reference and status lanes
// Assumes: bit clock arrives from another domain and is oversampled by clk_i
// Notes:   one bit per rising edge of the sampled bit clock on every lane
// Behaviour
// - every lane sends packets back to back without any gap
// - status lane carries metadata packets only
// - data lanes send pixel packets when described, empty packets otherwise
// - header of empty packets is switched on or off by configuration
// - random padding keeps the payload a multiple of 16 bits
// - 16-bit words; every packet is an even number of bytes
// - every field but the CRC goes out lsb first, low byte first
// - sync word has bits 1 and 3 set, all others clear
// - header sent three times when protected, else once
// - header bits 1:0 revision zero, bits 4:2 packet kind
// - header bits 12:5 hold the packet index within a line
// - header bits 14:13 hold sample width code 2 for 12 bits
// - bit 15 marks first frame row, bit 16 last frame row
// - header bits 18:17 hold row number modulo four
// - header bit 19 set exactly when padding was appended
// - header bits 31:20 give pixel count of pixel packets
// - metadata header holds only revision and kind, rest zero
// - metadata payload bits long, short, global, then thirteen zeros
// - packets with payload end in CRC-16 over payload with padding
// - CRC preset to ones per packet, sent top coefficient first
// - forwarded clock follows data with programmable phase, default 90
`timescale 1ns/1ps
`include "spf_defines.svh"

module spf_lane
    import spf_pkg::*;
#(
    parameter logic [2:0] LANE_KIND = `SPF_KIND_VIS,
    parameter bit         IS_STATUS = 1'b0
) (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // bit timing and configuration
    input  wire logic                     tick_i,
    input  wire logic                     hdr_prot_i,
    input  wire logic                     empty_hdr_i,
    // packet descriptors
    input  wire spf_desc_t                desc_i,
    input  wire logic                     desc_valid_i,
    output logic                          desc_ready_o,
    // pixel samples
    input  wire logic [`SPF_SMP_BITS-1:0] smp_i,
    input  wire logic                     smp_valid_i,
    output logic                          smp_ready_o,
    // metadata word
    input  wire spf_meta_t                meta_i,
    // serial lane
    output logic                          lane_o,
    output logic                          underrun_o
);
    localparam logic [31:0] SYNC = `SPF_SYNC_WORD;
    localparam spf_hdr_t    RST_HDR = IS_STATUS ?
        {27'h0, `SPF_KIND_META, `SPF_HDR_REV} : {27'h0, `SPF_KIND_EMPTY, `SPF_HDR_REV};

    spf_state_t  state;
    spf_hdr_t    hdr;
    spf_hdr_t    new_hdr;
    logic [4:0]  bit_cnt;
    logic [1:0]  rep_cnt;
    logic [1:0]  reps;
    logic        hdr_on;
    logic        has_pay;
    logic [15:0] pay_bits;
    logic [15:0] pay_sh;
    logic [15:0] crc;
    logic [15:0] lfsr;
    logic [15:0] bit_total;
    logic [11:0] pix_left;
    logic [4:0]  sh_left;
    logic [15:0] new_bits;
    logic [3:0]  new_pad;
    logic        use_desc;
    logic        last_bit;
    logic        launch;
    logic        hdr_end;
    logic        need_load;
    logic        take_pix;
    logic        next_bit;
    logic        fb;

    // a zero-length description has no payload, so it becomes an empty packet
    assign use_desc = !IS_STATUS && desc_valid_i &&
                      desc_i.payload_pixel_count != 12'h000;
    assign new_bits = 16'(desc_i.payload_pixel_count) * 16'(`SPF_SMP_BITS);
    assign new_pad  = 4'h0 - new_bits[3:0];

    always_comb begin
        new_hdr = '0;
        new_hdr.header_format_rev = `SPF_HDR_REV;
        if (IS_STATUS) begin
            new_hdr.packet_kind = `SPF_KIND_META;
        end else if (use_desc) begin
            new_hdr.packet_kind          = LANE_KIND;
            new_hdr.packet_index         = desc_i.packet_index;
            new_hdr.sample_width_code    = `SPF_WIDTH_12;
            new_hdr.frame_start_row_flag = desc_i.frame_start_row_flag;
            new_hdr.frame_end_row_flag   = desc_i.frame_end_row_flag;
            new_hdr.row_mod4             = desc_i.row_mod4;
            new_hdr.padded_flag          = new_pad != 4'h0;
            new_hdr.payload_pixel_count  = desc_i.payload_pixel_count;
        end else begin
            new_hdr.packet_kind = `SPF_KIND_EMPTY;
        end
    end

    assign hdr_end = state == ST_HDR && bit_cnt == 5'h1F && rep_cnt == reps - 2'h1;

    always_comb begin
        unique case (state)
            ST_SYNC: last_bit = bit_cnt == 5'h1F && !hdr_on;
            ST_HDR:  last_bit = hdr_end && !has_pay;
            ST_PAY:  last_bit = 1'b0;
            ST_CRC:  last_bit = bit_cnt == 5'h0F;
        endcase
    end

    // the next packet is chosen on the very bit that ends the current one
    assign launch       = tick_i && last_bit;
    assign desc_ready_o = launch && use_desc;
    assign need_load    = sh_left == 5'h00;
    assign take_pix     = state == ST_PAY && need_load && pix_left != 12'h000;
    assign smp_ready_o  = tick_i && take_pix;

    always_comb begin
        unique case (state)
            ST_SYNC: next_bit = SYNC[bit_cnt];
            ST_HDR:  next_bit = hdr[bit_cnt];
            ST_PAY: begin
                if (take_pix) begin
                    next_bit = smp_valid_i & smp_i[0];
                end else if (need_load) begin
                    next_bit = lfsr[0];
                end else begin
                    next_bit = pay_sh[0];
                end
            end
            ST_CRC:  next_bit = crc[4'hF - bit_cnt[3:0]];
        endcase
    end

    assign fb = crc[15] ^ next_bit;

    // packet sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state    <= ST_SYNC;
            bit_cnt  <= 5'h00;
            rep_cnt  <= 2'h0;
            reps     <= `SPF_REPS_PROT;
            hdr_on   <= 1'b1;
            has_pay  <= IS_STATUS;
            hdr      <= RST_HDR;
            pay_bits <= IS_STATUS ? 16'(`SPF_META_BITS) : 16'h0000;
        end else if (launch) begin
            state    <= ST_SYNC;
            bit_cnt  <= 5'h00;
            rep_cnt  <= 2'h0;
            reps     <= hdr_prot_i ? `SPF_REPS_PROT : `SPF_REPS_PLAIN;
            hdr_on   <= IS_STATUS || use_desc || empty_hdr_i;
            has_pay  <= IS_STATUS || use_desc;
            hdr      <= new_hdr;
            pay_bits <= IS_STATUS ? 16'(`SPF_META_BITS) : new_bits + 16'(new_pad);
        end else if (tick_i) begin
            unique case (state)
                ST_SYNC: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == 5'h1F) begin
                        state <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == 5'h1F) begin
                        rep_cnt <= rep_cnt + 2'h1;
                    end
                    if (hdr_end) begin
                        state <= ST_PAY;
                    end
                end
                ST_PAY: begin
                    pay_bits <= pay_bits - 16'h0001;
                    if (pay_bits == 16'h0001) begin
                        state <= ST_CRC;
                    end
                end
                ST_CRC: bit_cnt <= bit_cnt + 5'h01;
            endcase
        end
    end

    // payload shifting and checksum
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pay_sh   <= 16'h0000;
            sh_left  <= 5'h00;
            pix_left <= 12'h000;
            crc      <= `SPF_CRC_INIT;
        end else if (launch) begin
            crc      <= `SPF_CRC_INIT;
            sh_left  <= 5'h00;
            pix_left <= use_desc ? desc_i.payload_pixel_count : 12'h000;
        end else if (tick_i) begin
            // metadata is taken as late as possible, just before its payload
            if (IS_STATUS && hdr_end) begin
                pay_sh  <= 16'(meta_i);
                sh_left <= `SPF_META_BITS;
            end
            if (state == ST_PAY) begin
                crc <= {crc[14:0], 1'b0} ^ (fb ? `SPF_CRC_POLY : 16'h0000);
                if (take_pix) begin
                    pay_sh   <= {5'h00, smp_i[11:1]};
                    sh_left  <= 5'(`SPF_SMP_BITS - 1);
                    pix_left <= pix_left - 12'h001;
                end else if (!need_load) begin
                    pay_sh  <= {1'b0, pay_sh[15:1]};
                    sh_left <= sh_left - 5'h01;
                end
            end
        end
    end

    // serial output, pad source and packet length
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_o     <= 1'b0;
            underrun_o <= 1'b0;
            lfsr       <= `SPF_LFSR_SEED;
            bit_total  <= 16'h0000;
        end else begin
            underrun_o <= tick_i && take_pix && !smp_valid_i;
            if (tick_i) begin
                lane_o    <= next_bit;
                lfsr      <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
                bit_total <= launch ? 16'h0000 : bit_total + 16'h0001;
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_even_bytes: assert property (launch |-> bit_total[3:0] == 4'hF)
        else $error("packet length is not a whole number of 16-bit words");
    a_back_to_back: assert property (launch |=> state == ST_SYNC && bit_cnt == 5'h00)
        else $error("next packet did not start at once");
    a_sync_bits: assert property (tick_i && state == ST_SYNC |=>
        lane_o == SYNC[$past(bit_cnt)])
        else $error("sync bit wrong on lane");
    a_status_kind: assert property (!IS_STATUS || hdr.packet_kind == `SPF_KIND_META)
        else $error("status lane carries a non-metadata packet");
    a_crc_preset: assert property (launch |=> crc == `SPF_CRC_INIT)
        else $error("checksum not preset at packet start");
    a_hdr_reps: assert property (state == ST_HDR |-> rep_cnt < reps &&
        (reps == `SPF_REPS_PROT || reps == `SPF_REPS_PLAIN))
        else $error("header repeated a wrong number of times");
    a_pad_flag: assert property (hdr.padded_flag ==
        (hdr.payload_pixel_count[1:0] != 2'b00))
        else $error("padding flag disagrees with pixel count");
    a_width_code: assert property (has_pay && !IS_STATUS |->
        hdr.sample_width_code == `SPF_WIDTH_12)
        else $error("sample width code wrong in pixel header");
    a_crc_needs_pay: assert property (state == ST_CRC |-> has_pay)
        else $error("checksum sent on packet without payload");

    c_empty_bare: cover property (launch && !IS_STATUS && !use_desc && !empty_hdr_i);
    c_padded_pkt: cover property (state == ST_CRC && hdr.padded_flag);
    c_meta_pkt:   cover property (IS_STATUS && state == ST_CRC && bit_cnt == 5'h0F);
endmodule

module spf_framer
    import spf_pkg::*;
#(
    parameter int  N_PIX = 22,
    parameter int  N_OB  = 2,
    parameter int  PH_W  = 8,
    localparam int NL    = N_PIX + N_OB
) (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [7:0]                    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic [31:0]                        wb_dat_o,
    output logic                               wb_ack_o,
    // bit clock in, forwarded clock out
    input  wire logic                          bit_clk_i,
    output logic                               out_clk_o,
    // per data lane packet descriptors
    input  wire spf_desc_t [NL-1:0]            lane_desc_i,
    input  wire logic [NL-1:0]                 lane_desc_valid_i,
    output logic [NL-1:0]                      lane_desc_ready_o,
    // per data lane pixel samples
    input  wire logic [NL-1:0][`SPF_SMP_BITS-1:0] lane_smp_i,
    input  wire logic [NL-1:0]                 lane_smp_valid_i,
    output logic [NL-1:0]                      lane_smp_ready_o,
    // sensor state
    input  wire logic                          long_group_integrating_i,
    input  wire logic                          short_group_integrating_i,
    input  wire logic                          global_sample_active_i,
    // serial lanes
    output logic                               status_lane_o,
    output logic [N_PIX-1:0]                   pixel_lane_o,
    output logic [N_OB-1:0]                    black_ref_lane_o
);
    logic [2:0]      bclk_s;
    logic            bclk_lvl;
    logic            tick;
    logic            bclk_edge;
    logic [PH_W-1:0] half_cnt;
    logic [PH_W-1:0] half_len;
    logic [PH_W-1:0] dly;
    logic            q_pend;
    logic            q_tgt;
    logic            quad;
    logic [3:0]      ctrl;
    logic            undr;
    logic [NL-1:0]   lane_undr;
    logic            st_undr;
    logic [NL-1:0]   lanes;
    logic            req;
    logic            wr;
    spf_meta_t       meta;

    assign meta = {global_sample_active_i, short_group_integrating_i,
                   long_group_integrating_i};

    // bit clock sampling: a level counts once the second and third stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bclk_s   <= 3'h0;
            bclk_lvl <= 1'b0;
            tick     <= 1'b0;
        end else begin
            bclk_s <= {bclk_s[1:0], bit_clk_i};
            tick   <= bclk_s[1] == bclk_s[2] && bclk_s[2] && !bclk_lvl;
            if (bclk_s[1] == bclk_s[2]) begin
                bclk_lvl <= bclk_s[2];
            end
        end
    end

    assign bclk_edge = bclk_s[1] == bclk_s[2] && bclk_s[2] != bclk_lvl;

    // quadrature copy: each level change repeated half a measured half period later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half_cnt <= '0;
            half_len <= '0;
            dly      <= '0;
            q_pend   <= 1'b0;
            q_tgt    <= 1'b0;
            quad     <= 1'b0;
        end else if (bclk_edge) begin
            half_cnt <= '0;
            half_len <= half_cnt + PH_W'(1);
            dly      <= half_len >> 1;
            q_pend   <= 1'b1;
            q_tgt    <= bclk_s[2];
        end else begin
            if (half_cnt != '1) begin
                half_cnt <= half_cnt + PH_W'(1);
            end
            if (q_pend && dly == '0) begin
                quad   <= q_tgt;
                q_pend <= 1'b0;
            end else if (q_pend) begin
                dly <= dly - PH_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_clk_o <= 1'b0;
        end else begin
            unique case (ctrl[`SPF_CTRL_PH_HI:`SPF_CTRL_PH_LO])
                `SPF_PH_0:   out_clk_o <= bclk_lvl;
                `SPF_PH_90:  out_clk_o <= quad;
                `SPF_PH_180: out_clk_o <= !bclk_lvl;
                `SPF_PH_270: out_clk_o <= !quad;
            endcase
        end
    end

    // register bus
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // a write lands on the edge at which the master sees ack, while it still holds the request
    assign wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `SPF_CTRL_RST;
        end else if (wr && wb_adr_i == `SPF_ADR_CTRL) begin
            ctrl <= wb_dat_i[3:0];
        end
    end

    // a new underrun wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            undr <= 1'b0;
        end else if ((|lane_undr) || st_undr) begin
            undr <= 1'b1;
        end else if (wr && wb_adr_i == `SPF_ADR_STAT && wb_dat_i[`SPF_STAT_UNDR]) begin
            undr <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                unique case (wb_adr_i)
                    `SPF_ADR_CTRL: wb_dat_o <= {28'h0000000, ctrl};
                    `SPF_ADR_STAT: wb_dat_o <= {28'h0000000, meta, undr};
                    default:       wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    for (genvar i = 0; i < NL; i++) begin : g_lane
        spf_lane #(
            .LANE_KIND (i < N_PIX ? `SPF_KIND_VIS : `SPF_KIND_OB),
            .IS_STATUS (1'b0)
        ) u_lane (
            .clk_i        (clk_i),
            .rst_i        (rst_i),
            .tick_i       (tick),
            .hdr_prot_i   (ctrl[`SPF_CTRL_PROT]),
            .empty_hdr_i  (ctrl[`SPF_CTRL_EHDR]),
            .desc_i       (lane_desc_i[i]),
            .desc_valid_i (lane_desc_valid_i[i]),
            .desc_ready_o (lane_desc_ready_o[i]),
            .smp_i        (lane_smp_i[i]),
            .smp_valid_i  (lane_smp_valid_i[i]),
            .smp_ready_o  (lane_smp_ready_o[i]),
            .meta_i       (meta),
            .lane_o       (lanes[i]),
            .underrun_o   (lane_undr[i])
        );
    end

    spf_lane #(
        .LANE_KIND (`SPF_KIND_META),
        .IS_STATUS (1'b1)
    ) u_status (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .tick_i       (tick),
        .hdr_prot_i   (ctrl[`SPF_CTRL_PROT]),
        .empty_hdr_i  (ctrl[`SPF_CTRL_EHDR]),
        .desc_i       ('0),
        .desc_valid_i (1'b0),
        .desc_ready_o (),
        .smp_i        ('0),
        .smp_valid_i  (1'b0),
        .smp_ready_o  (),
        .meta_i       (meta),
        .lane_o       (status_lane_o),
        .underrun_o   (st_undr)
    );

    assign pixel_lane_o     = lanes[N_PIX-1:0];
    assign black_ref_lane_o = lanes[NL-1:N_PIX];

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge held longer than one cycle");
    c_wb_write: cover property (@(posedge clk_i) disable iff (rst_i)
        wr && wb_adr_i == `SPF_ADR_CTRL);
endmodule

// >>> spf_rx.sv
// Purpose: far-side receiver model of one serial lane
// Assumes: lane bit is settled at each bit clock rise
// Notes:   frames 32-bit words from the first sync word seen
`timescale 1ns/1ps
`include "spf_defines.svh"
module spf_rx (
    // link
    input  wire logic   bclk_i,
    input  wire logic   lane_i,
    // framed words
    output logic [31:0] word_o,
    output int          n_o
);
    logic [31:0] sh = '0;
    int          cnt = -1;
    initial n_o = 0;
    // own alignment per lane; later sync look-alikes never restart framing
    always @(posedge bclk_i) begin
        sh = {lane_i, sh[31:1]};
        if (cnt < 0) begin
            if (sh === `SPF_SYNC_WORD) cnt = 0;
        end else begin
            cnt = cnt + 1;
            if (cnt == 32) begin
                word_o <= sh;
                n_o    <= n_o + 1;
                cnt = 0;
            end
        end
    end
endmodule

// >>> tb.sv
// Purpose: self-checking bench of the packet framer
// Assumes: bit clock unrelated in phase to clk_i
// Notes:   lane 0 and the status lane are framed by receiver models
`timescale 1ns/1ps
`include "spf_defines.svh"
`define CHK(n,e,g) begin num_checks++; if ((g)!==(e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    import spf_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, bclk = 0, dv = 0;
    logic [7:0] adr = '0;
    logic [31:0] dat = '0, q, w, wp, ws, rd;
    logic [23:0] rdy, sr;
    logic [11:0] s = 12'hA5C;
    spf_desc_t dsc = '{12'h004, 2'h1, 1'b0, 1'b1, 8'h05};
    spf_hdr_t h;
    logic [1:0] pl;
    int np, ns, nb, nsr = 0, miscompares = 0, num_checks = 0, i;
    wire ack, sl, oc;
    wire [21:0] pl0;
    logic [31:0] wo;
    always #12.5 clk_i = ~clk_i;
    initial #7 forever #100 bclk = ~bclk;
    spf_framer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd),
        .wb_ack_o(ack), .bit_clk_i(bclk), .out_clk_o(oc), .lane_desc_i({24{dsc}}),
        .lane_desc_valid_i({23'h0, dv}), .lane_desc_ready_o(rdy), .lane_smp_i({24{s}}),
        .lane_smp_valid_i('1), .lane_smp_ready_o(sr), .long_group_integrating_i(1'b1),
        .short_group_integrating_i(1'b0), .global_sample_active_i(1'b1),
        .status_lane_o(sl), .pixel_lane_o(pl0), .black_ref_lane_o(pl));
    spf_rx i_rxp (.bclk_i(bclk), .lane_i(pl0[0]), .word_o(wp), .n_o(np));
    // black lane framed on the forwarded clock instead of the bit clock
    spf_rx i_rxb (.bclk_i(oc), .lane_i(pl[0]), .word_o(wo), .n_o(nb));
    always @(posedge clk_i) if (sr[0] === 1'b1) nsr <= nsr + 1;
    spf_rx i_rxs (.bclk_i(bclk), .lane_i(sl), .word_o(ws), .n_o(ns));
    task automatic finish_test();
        if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, wr, a, d};
        k = 0;
        do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
        q = rd;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin miscompares++; finish_test(); end
    endtask
    task automatic nxt(input bit st);
        int n0, k;
        n0 = st ? ns : np;
        for (k = 0; k < 20000 && (st ? ns : np) == n0; k++) @(posedge clk_i);
        if (k == 20000) begin miscompares++; finish_test(); end
        w = st ? ws : wp;
    endtask
    task automatic sync_up(input bit st);
        for (i = 0; i < 12 && w !== `SPF_SYNC_WORD; i++) nxt(st);
        if (w !== `SPF_SYNC_WORD) begin miscompares++; finish_test(); end
    endtask
    function automatic logic [31:0] ecrc(input logic [47:0] d, input int n, input logic [15:0] lo);
        logic [15:0] c;
        c = `SPF_CRC_INIT;
        for (int k = 0; k < n; k++) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? `SPF_CRC_POLY : 16'h0);
        for (int k = 0; k < 16; k++) ecrc[16+k] = c[15-k];
        ecrc[15:0] = lo;
    endfunction
    task automatic t_regs();
        wb(8'h00, 0, 0); `CHK("ctrl", 32'h7, q)
        wb(8'h04, 0, 0); `CHK("stat", 32'hA, q)
        wb(8'h08, 0, 0); `CHK("unmapped", 32'h0, q)
    endtask
    task automatic t_empty();
        w = '0; sync_up(0); nxt(0); q = w;
        `CHK("empty hdr", 5'h0, q[4:0])
        nxt(0); `CHK("copy 2", q, w)
        nxt(0); `CHK("copy 3", q, w)
        nxt(0); `CHK("sync", `SPF_SYNC_WORD, w)
    endtask
    task automatic t_meta();
        logic [31:0] hv [3];
        w = '0; sync_up(1);
        for (int k = 0; k < 3; k++) begin
            nxt(1); hv[k] = w; `CHK("meta hdr", 32'hC, w)
        end
        `CHK("meta vote", 32'hC, (hv[0] & hv[1]) | (hv[0] & hv[2]) | (hv[1] & hv[2]))
        nxt(1); `CHK("meta pay", ecrc(48'h5, 16, 16'h5), w)
        nxt(1); `CHK("meta next", `SPF_SYNC_WORD, w)
    endtask
    task automatic t_pixel();
        wb(8'h00, 1, 32'h4); wb(8'h00, 0, 0); `CHK("ctrl wr", 32'h4, q)
        for (int k = 0; k < 8; k++) nxt(0);
        `CHK("no hdr empty", `SPF_SYNC_WORD, w)
        @(posedge clk_i) dv <= 1;
        for (i = 0; i < 20000 && rdy[0] !== 1'b1; i++) @(posedge clk_i);
        dv <= 0;
        if (rdy[0] !== 1'b1) begin miscompares++; finish_test(); end
        for (i = 0; i < 12 && w === `SPF_SYNC_WORD; i++) nxt(0);
        if (i == 12) begin miscompares++; finish_test(); end
        h = '{12'h004, 1'b0, 2'h1, 1'b0, 1'b1, `SPF_WIDTH_12, 8'h05, `SPF_KIND_VIS, `SPF_HDR_REV};
        `CHK("pix hdr", h, w)
        nxt(0); `CHK("pix w1", {s[7:0], s, s}, w)
        nxt(0); `CHK("pix crc", ecrc({s, s, s, s}, 48, {s, s[11:8]}), w)
        nxt(0); `CHK("single hdr", `SPF_SYNC_WORD, w)
        `CHK("samples taken", 4, nsr)
        `CHK("ob via fwd clk", `SPF_SYNC_WORD, wo)
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        t_regs();
        t_empty();
        t_meta();
        t_pixel();
        finish_test();
    end
endmodule
